/* File: verilog/line_scan_map.vh */
// Shared constants for the line scan PCM multiplexer
`ifndef LINE_SCAN_MAP_VH
`define LINE_SCAN_MAP_VH

// PCM link framing: 32 channels of 10 bits per 125 us frame
`define NUM_CH          32
`define CH_IDX_W        5
`define CH_BITS         10
`define BIT_IDX_W       4
`define BIT_LAST        4'h9
`define CH_LAST         5'h1f
// Channels that may carry control messages toward the line cards
`define CH_CTRL_A       5'h00
`define CH_CTRL_B       5'h10

// Control message toward a line card: card address plus payload
`define CTRL_W          16

// Change-of-state report: card index and new state bit
`define COS_W           6

// Serial link timing, in ns, and the system clock period
`define CLK_PERIOD_NS   20
`define SER_BIT_NS      1000
`define SER_BIT_CYC     ((`SER_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SER_DIV_W       8
`define SER_CNT_W       3
// Bits still to follow once the first report bit is on the line
`define SER_LEFT_INIT   3'h5

// Serializer states, one-hot
`define ST_IDLE         2'b01
`define ST_SHIFT        2'b10

`endif

/* File: verilog/line_scan_pcm_multiplexer.v */
// Drawer bus interface card: two scan units, each serving one digroup of 32 line cards
//
// Summary of operation
// - Mux/demux one 32-channel 2.56 Mb/s link.
// - Queue line card messages; release in channels 0/16.
// - Scan 32 cards continuously; report each change.
// - Reports pass output buffer, then serial link.
// - Two identical independent units, 64 cards total.
`include "line_scan_map.vh"
`default_nettype none

// One scan unit: one digroup, one serial report link
module line_scan_unit #(
  parameter CQ_AW   = 2,                       // Control queue address width
  parameter SER_DIV = `SER_BIT_CYC             // Clock cycles per serial bit
) (
  // Clock and reset
  input  wire                          CLK,
  input  wire                          RESET_N,
  // PCM link, one bit per strobe
  input  wire                          PCM_BIT_STB,
  input  wire                          PCM_FSYNC,
  input  wire                          PCM_RX_DATA,
  output reg                           PCM_TX_DATA,
  // Line card buses, one 10-bit channel word per card
  output reg  [`NUM_CH*`CH_BITS-1:0]   LINE_RX_DATA,
  input  wire [`NUM_CH*`CH_BITS-1:0]   LINE_TX_DATA,
  input  wire [`NUM_CH-1:0]            LINE_STATE,
  // Control messages toward the line cards
  input  wire                          CTRL_IN_VALID,
  output wire                          CTRL_IN_READY,
  input  wire [`CTRL_W-1:0]            CTRL_IN_DATA,
  output reg                           LINE_MSG_VALID,
  output reg  [`CTRL_W-1:0]            LINE_MSG_DATA,
  // Serial report link to the shelf processor
  input  wire                          SER_HOLD,
  output reg                           SER_FRAME,
  output reg                           SER_DATA
);
  localparam CQ_DEPTH = 1 << CQ_AW;            // Control queue depth
  // Control slot test, used only to time message release
  function is_ctrl_ch;
    input [`CH_IDX_W-1:0] ch;
    begin
      is_ctrl_ch = (ch == `CH_CTRL_A) || (ch == `CH_CTRL_B);
    end
  endfunction
  // PCM framing state
  reg  [`BIT_IDX_W-1:0] bit_reg;               // Bit position in channel
  reg  [`CH_IDX_W-1:0]  ch_reg;                // Current channel
  reg  [`CH_BITS-1:0]   rx_shift_reg;          // Incoming channel word
  wire [`BIT_IDX_W-1:0] bit_cur;               // Bit position, frame sync applied
  wire [`CH_IDX_W-1:0]  ch_cur;                // Channel, frame sync applied
  wire [`CH_BITS-1:0]   rx_word;               // Word completed by this bit
  wire [`CH_BITS-1:0]   tx_word;               // Outgoing word of current channel
  wire                  word_done;             // Last bit of a channel taken
  // Frame sync forces the count back to channel 0, bit 0
  assign bit_cur   = PCM_FSYNC ? {`BIT_IDX_W{1'b0}} : bit_reg;
  assign ch_cur    = PCM_FSYNC ? {`CH_IDX_W{1'b0}} : ch_reg;
  assign rx_word   = {rx_shift_reg[`CH_BITS-2:0], PCM_RX_DATA};
  assign tx_word   = LINE_TX_DATA[ch_cur*`CH_BITS +: `CH_BITS];
  assign word_done = PCM_BIT_STB && (bit_cur == `BIT_LAST);
  // Bit and channel counters, demux into the line card buses
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bit_reg      <= {`BIT_IDX_W{1'b0}};
      ch_reg       <= {`CH_IDX_W{1'b0}};
      rx_shift_reg <= {`CH_BITS{1'b0}};
      LINE_RX_DATA <= {(`NUM_CH*`CH_BITS){1'b0}};
      PCM_TX_DATA  <= 1'b0;
    end else if (PCM_BIT_STB) begin
      rx_shift_reg <= rx_word;
      // Mux: drive the bit of this card's word, MSB first
      PCM_TX_DATA  <= tx_word[`BIT_LAST - bit_cur];
      if (bit_cur == `BIT_LAST) begin
        bit_reg <= {`BIT_IDX_W{1'b0}};
        // Channel count wraps after 32 channels
        ch_reg  <= ch_cur + {{(`CH_IDX_W-1){1'b0}}, 1'b1};
        // Demux: whole word lands on its own card's bus
        LINE_RX_DATA[ch_cur*`CH_BITS +: `CH_BITS] <= rx_word;
      end else begin
        bit_reg <= bit_cur + {{(`BIT_IDX_W-1){1'b0}}, 1'b1};
        ch_reg  <= ch_cur;
      end
    end
  end
  // Control message queue toward the line cards
  reg  [`CTRL_W-1:0] cq_mem [0:CQ_DEPTH-1];    // Stored messages
  reg  [CQ_AW-1:0]   cq_wr_reg;                // Write pointer
  reg  [CQ_AW-1:0]   cq_rd_reg;                // Read pointer
  reg  [CQ_AW:0]     cq_cnt_reg;               // Occupancy
  wire               cq_push;                  // Message accepted
  wire               cq_pop;                   // Message released in a slot
  assign CTRL_IN_READY = (cq_cnt_reg != CQ_DEPTH[CQ_AW:0]);
  assign cq_push       = CTRL_IN_VALID && CTRL_IN_READY;
  // Held until a channel 0 or 16 slot closes
  assign cq_pop        = word_done && is_ctrl_ch(ch_cur) && (cq_cnt_reg != 0);
  // Queue storage; memory has no reset, pointers guard it
  always @(posedge CLK) begin
    if (cq_push) begin
      cq_mem[cq_wr_reg] <= CTRL_IN_DATA;
    end
  end
  // Queue pointers and release toward the cards
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cq_wr_reg      <= {CQ_AW{1'b0}};
      cq_rd_reg      <= {CQ_AW{1'b0}};
      cq_cnt_reg     <= {(CQ_AW+1){1'b0}};
      LINE_MSG_VALID <= 1'b0;
      LINE_MSG_DATA  <= {`CTRL_W{1'b0}};
    end else begin
      LINE_MSG_VALID <= cq_pop;
      cq_wr_reg      <= cq_wr_reg + {{(CQ_AW-1){1'b0}}, cq_push};
      if (cq_pop) begin
        LINE_MSG_DATA <= cq_mem[cq_rd_reg];
        cq_rd_reg     <= cq_rd_reg + {{(CQ_AW-1){1'b0}}, 1'b1};
      end
      // Simultaneous push and pop cancel, so the count never drifts
      cq_cnt_reg     <= cq_cnt_reg + {{CQ_AW{1'b0}}, cq_push} - {{CQ_AW{1'b0}}, cq_pop};
    end
  end
  // Change-of-state scanner
  reg  [`CH_IDX_W-1:0] scan_reg;               // Card under scan
  reg  [`NUM_CH-1:0]   known_reg;              // Last reported state per card
  wire                 scan_cur;               // Live state of scanned card
  wire                 scan_change;            // Differs from last report
  wire                 buf_in_ready;           // Output buffer has room
  wire [`COS_W-1:0]    scan_msg;               // Report: index and new state
  assign scan_cur    = LINE_STATE[scan_reg];
  assign scan_change = (scan_cur != known_reg[scan_reg]);
  assign scan_msg    = {scan_reg, scan_cur};
  // Scan pointer stops on an unreported change while the buffer is full,
  // so the change is kept in known_reg's mismatch rather than dropped
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scan_reg  <= {`CH_IDX_W{1'b0}};
      known_reg <= {`NUM_CH{1'b0}};
    end else if (!scan_change || buf_in_ready) begin
      // Wraps over all 32 cards forever
      scan_reg <= scan_reg + {{(`CH_IDX_W-1){1'b0}}, 1'b1};
      if (scan_change) begin
        known_reg[scan_reg] <= scan_cur;
      end
    end
  end
  // Two-entry output buffer between scanner and serial link
  reg  [`COS_W-1:0] ob_mem [0:1];              // Buffered reports
  reg               ob_wr_reg;                 // Write slot
  reg               ob_rd_reg;                 // Read slot
  reg  [1:0]        ob_cnt_reg;                // Occupancy, 0 to 2
  wire              ob_push;                   // Report enters
  wire              ob_pop;                    // Serializer takes one
  wire              ob_valid;                  // Report available
  assign buf_in_ready = (ob_cnt_reg != 2'h2);
  assign ob_valid     = (ob_cnt_reg != 2'h0);
  assign ob_push      = scan_change && buf_in_ready;
  // Buffer storage
  always @(posedge CLK) begin
    if (ob_push) begin
      ob_mem[ob_wr_reg] <= scan_msg;
    end
  end
  // Buffer pointers
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ob_wr_reg  <= 1'b0;
      ob_rd_reg  <= 1'b0;
      ob_cnt_reg <= 2'h0;
    end else begin
      // Each slot pointer flips on its own transfer; push and pop together cancel
      ob_wr_reg  <= ob_wr_reg ^ ob_push;
      ob_rd_reg  <= ob_rd_reg ^ ob_pop;
      ob_cnt_reg <= ob_cnt_reg + {1'b0, ob_push} - {1'b0, ob_pop};
    end
  end
  // Serial report link: frame high while 6 bits go out MSB first
  reg  [1:0]            st_reg;                // Serializer state
  reg  [`COS_W-1:0]     ser_shift_reg;         // Bits still to send
  reg  [`SER_CNT_W-1:0] ser_left_reg;          // Bits remaining in frame
  reg  [`SER_DIV_W-1:0] ser_div_reg;           // Bit period divider
  wire                  ser_tick;              // End of one bit period
  // Hold from the processor only delays the next frame, never cuts one
  assign ob_pop   = (st_reg == `ST_IDLE) && ob_valid && !SER_HOLD;
  assign ser_tick = (ser_div_reg == SER_DIV[`SER_DIV_W-1:0] - 8'h01);
  // Serializer state machine
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg        <= `ST_IDLE;
      ser_shift_reg <= {`COS_W{1'b0}};
      ser_left_reg  <= {`SER_CNT_W{1'b0}};
      ser_div_reg   <= {`SER_DIV_W{1'b0}};
      SER_FRAME     <= 1'b0;
      SER_DATA      <= 1'b0;
    end else begin
      case (st_reg)
        `ST_IDLE: begin
          ser_div_reg <= {`SER_DIV_W{1'b0}};
          if (ob_pop) begin
            // First bit appears together with the frame
            SER_FRAME     <= 1'b1;
            SER_DATA      <= ob_mem[ob_rd_reg][`COS_W-1];
            ser_shift_reg <= {ob_mem[ob_rd_reg][`COS_W-2:0], 1'b0};
            ser_left_reg  <= `SER_LEFT_INIT;
            st_reg        <= `ST_SHIFT;
          end
        end
        `ST_SHIFT: begin
          if (ser_tick) begin
            ser_div_reg <= {`SER_DIV_W{1'b0}};
            if (ser_left_reg == {`SER_CNT_W{1'b0}}) begin
              // Frame over after the last bit period
              SER_FRAME <= 1'b0;
              SER_DATA  <= 1'b0;
              st_reg    <= `ST_IDLE;
            end else begin
              SER_DATA      <= ser_shift_reg[`COS_W-1];
              ser_shift_reg <= {ser_shift_reg[`COS_W-2:0], 1'b0};
              ser_left_reg  <= ser_left_reg - 3'h1;
            end
          end else begin
            ser_div_reg <= ser_div_reg + 8'h01;
          end
        end
        default: begin
          // Illegal code: back to idle without a frame
          st_reg    <= `ST_IDLE;
          SER_FRAME <= 1'b0;
          SER_DATA  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// Top: two independent scan units, unit 0 on the low port slices
module line_scan_pcm_multiplexer #(
  parameter CQ_AW   = 2,                       // Control queue address width
  parameter SER_DIV = `SER_BIT_CYC             // Clock cycles per serial bit
) (
  // Clock and reset
  input  wire                            CLK,
  input  wire                            RESET_N,
  // PCM links, one per digroup
  input  wire [1:0]                      PCM_BIT_STB,
  input  wire [1:0]                      PCM_FSYNC,
  input  wire [1:0]                      PCM_RX_DATA,
  output wire [1:0]                      PCM_TX_DATA,
  // Line card buses, 64 cards
  output wire [2*`NUM_CH*`CH_BITS-1:0]   LINE_RX_DATA,
  input  wire [2*`NUM_CH*`CH_BITS-1:0]   LINE_TX_DATA,
  input  wire [2*`NUM_CH-1:0]            LINE_STATE,
  // Control messages toward the line cards
  input  wire [1:0]                      CTRL_IN_VALID,
  output wire [1:0]                      CTRL_IN_READY,
  input  wire [2*`CTRL_W-1:0]            CTRL_IN_DATA,
  output wire [1:0]                      LINE_MSG_VALID,
  output wire [2*`CTRL_W-1:0]            LINE_MSG_DATA,
  // Serial report links
  input  wire [1:0]                      SER_HOLD,
  output wire [1:0]                      SER_FRAME,
  output wire [1:0]                      SER_DATA
);
  genvar u;
  // Each unit sees only its own digroup and subgroup
  generate
    for (u = 0; u < 2; u = u + 1) begin : g_unit
      line_scan_unit #(
        .CQ_AW   (CQ_AW),
        .SER_DIV (SER_DIV)
      ) u_scan (
        .CLK            (CLK),
        .RESET_N        (RESET_N),
        .PCM_BIT_STB    (PCM_BIT_STB[u]),
        .PCM_FSYNC      (PCM_FSYNC[u]),
        .PCM_RX_DATA    (PCM_RX_DATA[u]),
        .PCM_TX_DATA    (PCM_TX_DATA[u]),
        .LINE_RX_DATA   (LINE_RX_DATA[u*`NUM_CH*`CH_BITS +: `NUM_CH*`CH_BITS]),
        .LINE_TX_DATA   (LINE_TX_DATA[u*`NUM_CH*`CH_BITS +: `NUM_CH*`CH_BITS]),
        .LINE_STATE     (LINE_STATE[u*`NUM_CH +: `NUM_CH]),
        .CTRL_IN_VALID  (CTRL_IN_VALID[u]),
        .CTRL_IN_READY  (CTRL_IN_READY[u]),
        .CTRL_IN_DATA   (CTRL_IN_DATA[u*`CTRL_W +: `CTRL_W]),
        .LINE_MSG_VALID (LINE_MSG_VALID[u]),
        .LINE_MSG_DATA  (LINE_MSG_DATA[u*`CTRL_W +: `CTRL_W]),
        .SER_HOLD       (SER_HOLD[u]),
        .SER_FRAME      (SER_FRAME[u]),
        .SER_DATA       (SER_DATA[u])
      );
    end
  endgenerate
endmodule

`default_nettype wire

/* File: testbench/line_scan_checker.sv */
// Port checker for the two-unit line scan multiplexer
`default_nettype none
module line_scan_checker #(
  parameter SER_DIV = 50                  // Clock cycles per serial bit
) (
  // Clock, reset and PCM side
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic [1:0] PCM_BIT_STB,
  input wire logic [1:0] PCM_FSYNC,
  input wire logic [1:0] PCM_TX_DATA,
  // Message queue and serial report side
  input wire logic [1:0] CTRL_IN_VALID,
  input wire logic [1:0] CTRL_IN_READY,
  input wire logic [1:0] LINE_MSG_VALID,
  input wire logic [1:0] SER_HOLD,
  input wire logic [1:0] SER_FRAME,
  input wire logic [1:0] SER_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] pos_reg;                    // Next bit position of unit 0
  logic [8:0] cur_pos;                    // Position of the bit taken now
  logic       slot_hit;                   // Last bit of channel 0 or 16
  logic [2:0] occ_reg;                    // Messages waiting in unit 0
  logic [9:0] frm_reg;                    // Cycles the frame has been up
  assign cur_pos  = PCM_FSYNC[0] ? 9'h000 : pos_reg;
  assign slot_hit = PCM_BIT_STB[0] && (cur_pos == 9'h009 || cur_pos == 9'h0a9);
  // Shadow frame position, queue fill and frame length
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pos_reg <= 9'h000;
      occ_reg <= 3'h0;
      frm_reg <= 10'h000;
    end else begin
      if (PCM_BIT_STB[0]) begin
        pos_reg <= (cur_pos == 9'h13f) ? 9'h000 : cur_pos + 9'h001;
      end
      occ_reg <= occ_reg + {2'b00, CTRL_IN_VALID[0] && CTRL_IN_READY[0]}
                 - {2'b00, slot_hit && occ_reg != 3'h0};
      frm_reg <= SER_FRAME[0] ? frm_reg + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // A report frame is a run of high cycles followed by the first low one
  sequence s_frame_end;
    SER_FRAME[0] ##1 !SER_FRAME[0];
  endsequence
  a_tx_still: assert property (PCM_BIT_STB == 2'b00 |=> $stable(PCM_TX_DATA))
    else $error("link bit moved without a strobe");
  a_msg_slot: assert property (LINE_MSG_VALID[0] |-> $past(slot_hit))
    else $error("message released outside a control slot");
  a_msg_pulse: assert property (LINE_MSG_VALID[0] |=> !LINE_MSG_VALID[0])
    else $error("message strobe longer than one cycle");
  a_ready_full: assert property (CTRL_IN_READY[0] == (occ_reg != 3'h4))
    else $error("queue ready does not match its fill");
  a_frame_len: assert property (s_frame_end |-> frm_reg == 6 * SER_DIV)
    else $error("report frame has the wrong length");
  a_idle_data: assert property (!SER_FRAME[0] |-> !SER_DATA[0])
    else $error("serial data active outside a frame");
  a_bit_steady: assert property (
      SER_FRAME[0] && frm_reg % SER_DIV != 0 |-> $stable(SER_DATA[0]))
    else $error("serial bit changed inside its period");
  a_hold_blocks: assert property (
      $past(SER_HOLD[0]) && SER_HOLD[0] && !SER_FRAME[0] |=> !SER_FRAME[0])
    else $error("frame started while held off");
endmodule
`default_nettype wire

/* File: testbench/shelf_proc_model.sv */
// Behavioural shelf processor taking serial change-of-state reports
`default_nettype none
module shelf_proc_model #(
  parameter DIV = 2                       // Clock cycles per serial bit
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       frame,          // Report frame from the scan unit
  input  wire logic       data,           // Report bit, card index first
  input  wire logic       stall,          // Bench asks to hold off frames
  output logic            hold,           // Flow control to the scan unit
  output logic [5:0]      rpt,            // Bits of the last finished frame, any length
  output logic            rpt_v           // One-cycle strobe per report
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cnt_reg;                    // Cycles spent in this frame
  logic [5:0] sh_reg;                     // Bits gathered so far
  // Hold is a plain level; a busy processor keeps it up
  assign hold = stall;
  // Sample at the end of each bit, clear of its edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 10'h000;
      sh_reg  <= 6'h00;
      rpt     <= 6'h00;
      rpt_v   <= 1'b0;
    end else begin
      rpt_v <= 1'b0;
      if (frame) begin
        cnt_reg <= cnt_reg + 10'h001;
        if (cnt_reg % DIV == DIV - 1) begin
          sh_reg <= {sh_reg[4:0], data};
        end
      end else if (cnt_reg != 10'h000) begin
        // Frames of wrong length are dropped, so the bench sees them missing
        rpt     <= sh_reg;
        rpt_v   <= (cnt_reg == 6 * DIV);
        cnt_reg <= 10'h000;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_line_scan_pcm_multiplexer.sv */
// Self-checking bench for the two-unit line scan multiplexer
`include "line_scan_map.vh"
`default_nettype none
module test_line_scan_pcm_multiplexer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam DIV = 2;                     // Short serial bit keeps runs quick
  logic         CLK = 1'b0;
  logic         RESET_N = 1'b0;
  logic [1:0]   stb = 0, fsync = 0, rx = 0, cvalid = 0, stall = 0;
  wire logic [1:0] tx, cready, mvalid, hold, frame, sdata, rpt_v;
  logic [639:0] rx_words, tx_words;       // Words into and out of the cards
  wire logic [639:0] rx_words_got;        // Words as delivered to the cards
  logic [63:0]  state = 0;                // Card state levels
  logic [31:0]  cdata = 0, mdata;
  logic [5:0]   rpt [2];
  logic [15:0]  mq [2][$];                // Released messages per unit
  logic [5:0]   rq [2][$];                // Received reports per unit
  int           bad_count = 0, tests_run = 0, pos = 0;
  always #10 CLK = ~CLK;
  line_scan_pcm_multiplexer #(.CQ_AW(2), .SER_DIV(DIV)) u_dut (.CLK(CLK), .RESET_N(RESET_N),
    .PCM_BIT_STB(stb), .PCM_FSYNC(fsync), .PCM_RX_DATA(rx), .PCM_TX_DATA(tx),
    .LINE_RX_DATA(rx_words_got), .LINE_TX_DATA(tx_words), .LINE_STATE(state),
    .CTRL_IN_VALID(cvalid), .CTRL_IN_READY(cready), .CTRL_IN_DATA(cdata),
    .LINE_MSG_VALID(mvalid), .LINE_MSG_DATA(mdata), .SER_HOLD(hold), .SER_FRAME(frame),
    .SER_DATA(sdata));
  shelf_proc_model #(.DIV(DIV)) u_sp0 (.clk(CLK), .reset_n(RESET_N), .frame(frame[0]),
    .data(sdata[0]), .stall(stall[0]), .hold(hold[0]), .rpt(rpt[0]), .rpt_v(rpt_v[0]));
  shelf_proc_model #(.DIV(DIV)) u_sp1 (.clk(CLK), .reset_n(RESET_N), .frame(frame[1]),
    .data(sdata[1]), .stall(stall[1]), .hold(hold[1]), .rpt(rpt[1]), .rpt_v(rpt_v[1]));
  // Gather released messages and received reports as they appear
  always @(posedge CLK) begin
    for (int u = 0; u < 2; u++) begin
      if (rpt_v[u]) rq[u].push_back(rpt[u]);
      if (mvalid[u]) mq[u].push_back(mdata[u*16 +: 16]);
    end
  end
  function automatic logic [9:0] wd(input int u, input int c, input bit t);
    return t ? {c[4:0] ^ 5'h15, u[0], 4'h6} : {c[4:0] ^ {5{u[0]}}, 5'h13};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Back-to-back strobes; each link bit out is checked two edges later
  task automatic pcm_bits(input int n);
    logic [1:0] e1, e2;
    bit         v1, v2;
    int         k;
    {v1, v2, e1, e2} = 0;
    for (int i = 0; i < n + 2; i++) begin
      @(posedge CLK);
      if (v2) check(tx, e2);
      v2 = v1;
      e2 = e1;
      v1 = i < n;
      for (int u = 0; u < 2; u++) begin
        k = u * 320 + (pos / 10) * 10 + 9 - pos % 10;
        e1[u] = tx_words[k];
        rx[u] <= rx_words[k];
      end
      stb <= v1 ? 2'b11 : 2'b00;
      fsync <= (v1 && pos == 0) ? 2'b11 : 2'b00;
      if (v1) pos = (pos + 1) % 320;
    end
  endtask
  task automatic push(input int u, input logic [15:0] d, input bit ok);
    @(posedge CLK);
    cvalid[u] <= 1'b1;
    cdata[u*16 +: 16] <= d;
    @(posedge CLK);
    check(cready[u], ok);
    cvalid[u] <= 1'b0;
  endtask
  task automatic test_pcm;
    pcm_bits(320);
    for (int i = 0; i < 64; i++) check(rx_words_got[i*10 +: 10], rx_words[i*10 +: 10]);
    $display("test_pcm done");
  endtask
  // Fill the queue past full, then drain it through four control slots
  task automatic test_ctrl;
    for (int k = 0; k < 5; k++) push(0, 16'h5a00 + k[15:0], k < 4);
    push(1, 16'hc3c3, 1'b1);
    pcm_bits(660);
    check(mq[0].size(), 4);
    for (int k = 0; k < 4; k++) check(mq[0][k], 16'h5a00 + k[15:0]);
    check(mq[1].size(), 1);
    check(mq[1][0], 16'hc3c3);
    push(0, 16'h5a04, 1'b1);
    $display("test_ctrl done");
  endtask
  // Changes pile up behind a held link, then drain with the scanner stalling
  task automatic test_scan;
    logic [63:0] chg;
    logic [31:0] mask;
    chg = 64'h00000020_40101008;
    @(posedge CLK);
    stall <= 2'b11;
    state <= chg;
    repeat (100) @(posedge CLK);
    check(frame, 2'b00);
    for (int lvl = 1; lvl >= 0; lvl--) begin
      stall <= 2'b00;
      if (lvl == 0) state <= 64'h0;
      repeat (400) @(posedge CLK);
      mask = 0;
      foreach (rq[0][j]) begin
        mask[rq[0][j][5:1]] = 1'b1;
        check(rq[0][j][0], lvl[0]);
      end
      check(rq[0].size(), 4);
      check(mask, chg[31:0]);
      check(rq[1].size(), 1);
      check(rq[1][0], {5'h05, lvl[0]});
      rq[0].delete();
      rq[1].delete();
    end
    $display("test_scan done");
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 64; i++) begin
      tx_words[i*10 +: 10] = wd(i / 32, i % 32, 1'b1);
      rx_words[i*10 +: 10] = wd(i / 32, i % 32, 1'b0);
    end
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    test_pcm();
    test_ctrl();
    test_scan();
    finish_test();
  end
  // Watchdog: the run needs some 1900 cycles
  initial begin
    #200us;
    bad_count++;
    finish_test();
  end
endmodule
bind line_scan_pcm_multiplexer line_scan_checker #(.SER_DIV(SER_DIV)) u_chk (.CLK(CLK),
  .RESET_N(RESET_N), .PCM_BIT_STB(PCM_BIT_STB), .PCM_FSYNC(PCM_FSYNC),
  .PCM_TX_DATA(PCM_TX_DATA), .CTRL_IN_VALID(CTRL_IN_VALID), .CTRL_IN_READY(CTRL_IN_READY),
  .LINE_MSG_VALID(LINE_MSG_VALID), .SER_HOLD(SER_HOLD), .SER_FRAME(SER_FRAME),
  .SER_DATA(SER_DATA));
`default_nettype wire
